/* logic/pbf_map.svh */
// widths, reset values and field positions of the port b / port f pin mux
// Behaviour
// - port b pins come up as general-purpose io
// - each pin individually input or output in io
// - clearing port b pullup bit n disables pin n
// - bit 4 clear disables pullup on clock pin
// - idle bus tri-states address and control, unless drive
// - idle bus tri-states data pins, unless drive
// - peripheral enable, then select picks address or clock on pin 4
// - port f pins come up in data-bus function
// - clearing port f pullup bit n disables pin n
`ifndef PBF_MAP_SVH
`define PBF_MAP_SVH

`define PBF_B_WIDTH      5
`define PBF_F_WIDTH      4
`define PBF_CFG_WIDTH    5
`define PBF_CLK_PIN      4
`define PBF_B_PER_RST    5'h00
`define PBF_F_PER_RST    4'hf
`define PBF_B_PUR_RST    5'h1f
`define PBF_F_PUR_RST    4'hf
`define PBF_B_DATA_RST   5'h00
`define PBF_F_DATA_RST   4'h0
`define PBF_B_DIR_RST    5'h00
`define PBF_F_DIR_RST    4'h0
`define PBF_CLKOUT_RST   1'b0
`define PBF_DRIVE_RST    1'b0

`endif

/* logic/pbf_pin_mux.sv */
// pin function select for port b (io / high address / clock monitor) and port f (io / data)
`include "pbf_map.svh"
module pbf_pin_mux (
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic                      cfg_wr,
  input  wire pbf_pkg::pbf_cfg_sel_t     cfg_sel,
  input  wire logic [`PBF_CFG_WIDTH-1:0] cfg_wdata,
  input  wire logic                      ext_bus_active,
  input  wire logic                      ext_data_write,
  input  wire logic [`PBF_B_WIDTH-1:0]   ext_addr,
  input  wire logic [`PBF_F_WIDTH-1:0]   ext_data_out,
  input  wire logic                      prescaler_clock,
  input  wire logic [`PBF_B_WIDTH-1:0]   port_b_pin_in,
  input  wire logic [`PBF_F_WIDTH-1:0]   port_f_pin_in,
  output logic      [`PBF_B_WIDTH-1:0]   port_b_pin_out,
  output logic      [`PBF_B_WIDTH-1:0]   port_b_pin_oe,
  output logic      [`PBF_B_WIDTH-1:0]   port_b_pullup,
  output logic      [`PBF_F_WIDTH-1:0]   port_f_pin_out,
  output logic      [`PBF_F_WIDTH-1:0]   port_f_pin_oe,
  output logic      [`PBF_F_WIDTH-1:0]   port_f_pullup,
  output logic      [`PBF_B_WIDTH-1:0]   port_b_in,
  output logic      [`PBF_F_WIDTH-1:0]   port_f_in,
  output logic      [`PBF_B_WIDTH-1:0]   port_b_peripheral_enable,
  output logic      [`PBF_F_WIDTH-1:0]   port_f_peripheral_enable,
  output logic                           ext_ctrl_oe
);
  // configuration state
  logic [`PBF_B_WIDTH-1:0] b_data;
  logic [`PBF_B_WIDTH-1:0] b_dir;
  logic [`PBF_B_WIDTH-1:0] b_per;
  logic [`PBF_B_WIDTH-1:0] b_pur;
  logic [`PBF_F_WIDTH-1:0] f_data;
  logic [`PBF_F_WIDTH-1:0] f_dir;
  logic [`PBF_F_WIDTH-1:0] f_per;
  logic [`PBF_F_WIDTH-1:0] f_pur;
  logic                    clock_out_select;
  logic                    bus_idle_drive_control;
  logic [`PBF_B_WIDTH-1:0] next_b_data;
  logic [`PBF_B_WIDTH-1:0] next_b_dir;
  logic [`PBF_B_WIDTH-1:0] next_b_per;
  logic [`PBF_B_WIDTH-1:0] next_b_pur;
  logic [`PBF_F_WIDTH-1:0] next_f_data;
  logic [`PBF_F_WIDTH-1:0] next_f_dir;
  logic [`PBF_F_WIDTH-1:0] next_f_per;
  logic [`PBF_F_WIDTH-1:0] next_f_pur;
  logic                    next_clock_out_select;
  logic                    next_bus_idle_drive_control;
  // pin drive state
  logic [`PBF_B_WIDTH-1:0] next_b_out;
  logic [`PBF_B_WIDTH-1:0] next_b_oe;
  logic [`PBF_F_WIDTH-1:0] next_f_out;
  logic [`PBF_F_WIDTH-1:0] next_f_oe;
  logic                    next_ctrl_oe;
  logic                    addr_oe;
  logic                    data_oe;

  // write hit for one configuration register
  function automatic logic cfg_hit(input logic                  wr,
                                   input pbf_pkg::pbf_cfg_sel_t sel,
                                   input pbf_pkg::pbf_cfg_sel_t target);
    return wr && (sel == target);
  endfunction

  // input synchronisers for both ports
  pbf_sync_if #(.WIDTH(`PBF_B_WIDTH)) b_sif ();
  pbf_sync_if #(.WIDTH(`PBF_F_WIDTH)) f_sif ();
  assign b_sif.raw = port_b_pin_in;
  assign f_sif.raw = port_f_pin_in;
  assign port_b_in = b_sif.level;
  assign port_f_in = f_sif.level;

  pbf_sync_filter #(.WIDTH(`PBF_B_WIDTH)) u_b_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sif     (b_sif)
  );
  pbf_sync_filter #(.WIDTH(`PBF_F_WIDTH)) u_f_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sif     (f_sif)
  );

  // configuration writes
  always_comb begin
    next_b_data = b_data;
    next_b_dir  = b_dir;
    next_b_per  = b_per;
    next_b_pur  = b_pur;
    next_f_data = f_data;
    next_f_dir  = f_dir;
    next_f_per  = f_per;
    next_f_pur  = f_pur;
    next_clock_out_select       = clock_out_select;
    next_bus_idle_drive_control = bus_idle_drive_control;
    if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_B_DATA)) begin
      next_b_data = cfg_wdata;
    end else if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_B_DIR)) begin
      next_b_dir = cfg_wdata;
    end else if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_B_PER)) begin
      next_b_per = cfg_wdata;
    end else if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_B_PUR)) begin
      next_b_pur = cfg_wdata;
    end else if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_F_DATA)) begin
      next_f_data = cfg_wdata[`PBF_F_WIDTH-1:0];
    end else if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_F_DIR)) begin
      next_f_dir = cfg_wdata[`PBF_F_WIDTH-1:0];
    end else if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_F_PER)) begin
      next_f_per = cfg_wdata[`PBF_F_WIDTH-1:0];
    end else if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_F_PUR)) begin
      next_f_pur = cfg_wdata[`PBF_F_WIDTH-1:0];
    end else if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_CLKOUT)) begin
      next_clock_out_select = cfg_wdata[0];
    end else if (cfg_hit(cfg_wr, cfg_sel, pbf_pkg::PBF_SEL_DRIVE)) begin
      next_bus_idle_drive_control = cfg_wdata[0];
    end
  end

  // configuration registers with reset defaults
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      b_data <= `PBF_B_DATA_RST;
      b_dir  <= `PBF_B_DIR_RST;
      b_per  <= `PBF_B_PER_RST;
      b_pur  <= `PBF_B_PUR_RST;
      f_data <= `PBF_F_DATA_RST;
      f_dir  <= `PBF_F_DIR_RST;
      f_per  <= `PBF_F_PER_RST;
      f_pur  <= `PBF_F_PUR_RST;
      clock_out_select       <= `PBF_CLKOUT_RST; // address function after reset
      bus_idle_drive_control <= `PBF_DRIVE_RST;  // tri-state when idle after reset
    end else begin
      b_data <= next_b_data;
      b_dir  <= next_b_dir;
      b_per  <= next_b_per;
      b_pur  <= next_b_pur;
      f_data <= next_f_data;
      f_dir  <= next_f_dir;
      f_per  <= next_f_per;
      f_pur  <= next_f_pur;
      clock_out_select       <= next_clock_out_select;
      bus_idle_drive_control <= next_bus_idle_drive_control;
    end
  end

  // bus-side enables: address drives while active, data only on active writes; else only when idle drive is set
  assign addr_oe = ext_bus_active | bus_idle_drive_control;
  assign data_oe = ext_bus_active ? ext_data_write : bus_idle_drive_control;

  // pin function mux for both ports
  always_comb begin
    next_b_out   = b_data;
    next_b_oe    = b_dir;
    next_f_out   = f_data;
    next_f_oe    = f_dir;
    next_ctrl_oe = addr_oe;
    for (int i = 0; i < `PBF_B_WIDTH; i++) begin
      if (b_per[i]) begin
        next_b_out[i] = ext_addr[i];
        next_b_oe[i]  = addr_oe;
        if (i == `PBF_CLK_PIN && clock_out_select) begin
          next_b_out[i] = prescaler_clock;
          next_b_oe[i]  = 1'b1;
        end
      end
    end
    for (int j = 0; j < `PBF_F_WIDTH; j++) begin
      if (f_per[j]) begin
        next_f_out[j] = ext_data_out[j];
        next_f_oe[j]  = data_oe;
      end
    end
  end

  // registered pin drive
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port_b_pin_out <= '0;
      port_b_pin_oe  <= '0;
      port_f_pin_out <= '0;
      port_f_pin_oe  <= '0;
      ext_ctrl_oe    <= 1'b0;
    end else begin
      port_b_pin_out <= next_b_out;
      port_b_pin_oe  <= next_b_oe;
      port_f_pin_out <= next_f_out;
      port_f_pin_oe  <= next_f_oe;
      ext_ctrl_oe    <= next_ctrl_oe;
    end
  end

  // pullup and status outputs straight from registers
  assign port_b_pullup            = b_pur;
  assign port_f_pullup            = f_pur;
  assign port_b_peripheral_enable = b_per;
  assign port_f_peripheral_enable = f_per;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_clk_pin_enabled;
    b_per[`PBF_CLK_PIN] && !$past(sys_rst);
  endsequence
  sequence s_clk_selected;
    s_clk_pin_enabled ##0 clock_out_select;
  endsequence

  AST_B_RESET_IO: assert property (
    $fell(sys_rst) |-> b_per == 5'h00 && port_b_pin_oe == 5'h00)
    else $error("port b not in io after reset");
  AST_B_DIR: assert property (b_per == 5'h00 |=> port_b_pin_oe == $past(b_dir))
    else $error("port b enable not from direction");
  AST_F_DIR: assert property (f_per == 4'h0 |=> port_f_pin_oe == $past(f_dir))
    else $error("port f enable not from direction");
  AST_B_PULLUP: assert property (
    cfg_wr && cfg_sel == pbf_pkg::PBF_SEL_B_PUR |=> port_b_pullup == $past(cfg_wdata))
    else $error("port b pullup write lost");
  AST_B4_PULLUP: assert property (
    cfg_wr && cfg_sel == pbf_pkg::PBF_SEL_B_PUR && !cfg_wdata[4] |=> !port_b_pullup[4])
    else $error("pin 4 pullup still on");
  AST_ADDR_IDLE: assert property (
    b_per[0] && !ext_bus_active && !bus_idle_drive_control
    |=> !port_b_pin_oe[0] && !ext_ctrl_oe)
    else $error("address driven on idle bus");
  AST_DATA_IDLE: assert property (
    f_per[0] && !ext_bus_active && !bus_idle_drive_control |=> !port_f_pin_oe[0])
    else $error("data driven on idle bus");
  AST_CLK_OUT: assert property (
    s_clk_selected |=> port_b_pin_oe[4] && port_b_pin_out[4] == $past(prescaler_clock))
    else $error("clock monitor not on pin 4");
  AST_F_RESET_BUS: assert property (
    $fell(sys_rst) |-> f_per == 4'hf
    ##1 (f_per == 4'hf || $past(cfg_wr && cfg_sel == pbf_pkg::PBF_SEL_F_PER)))
    else $error("port f not in bus function after reset");
  AST_F_PULLUP: assert property (
    cfg_wr && cfg_sel == pbf_pkg::PBF_SEL_F_PUR && !cfg_wdata[0] |=> !port_f_pullup[0])
    else $error("port f pin 0 pullup still on");
  AST_F_PERIPH: assert property (
    f_per[1] && ext_bus_active && ext_data_write
    |=> port_f_pin_oe[1] && port_f_pin_out[1] == $past(ext_data_out[1]))
    else $error("port f data not from bus");
endmodule // pbf_pin_mux

/* logic/pbf_pkg.sv */
// types shared by the port b / port f pin mux
package pbf_pkg;
  // selects which configuration register a write lands in
  typedef enum logic [3:0] {
    PBF_SEL_B_DATA = 4'h0,
    PBF_SEL_B_DIR  = 4'h1,
    PBF_SEL_B_PER  = 4'h2,
    PBF_SEL_B_PUR  = 4'h3,
    PBF_SEL_F_DATA = 4'h4,
    PBF_SEL_F_DIR  = 4'h5,
    PBF_SEL_F_PER  = 4'h6,
    PBF_SEL_F_PUR  = 4'h7,
    PBF_SEL_CLKOUT = 4'h8,
    PBF_SEL_DRIVE  = 4'h9
  } pbf_cfg_sel_t;
endpackage

/* logic/pbf_sync_filter.sv */
// three-stage pin input synchroniser with agreement filter
module pbf_sync_filter #(
  parameter int WIDTH = 1
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  pbf_sync_if.filt  sif
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  // a bit changes only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        next_level[gi] = (stage2[gi] == stage3[gi]) ? stage3[gi] : level[gi];
      end
    end
  endgenerate

  // shift chain; stage1 feeds only stage2
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= sif.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign sif.level = level;
endmodule // pbf_sync_filter

/* logic/pbf_sync_if.sv */
// carrier between the pin mux and its input synchroniser
interface pbf_sync_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;
  modport filt (input raw, output level);
  modport user (output raw, input level);
endinterface

/* sim/pbf_board_model.sv */
// board model: resolves port b / port f pin levels from chip drive, board drive and pullups
`include "pbf_map.svh"
module pbf_board_model (
  input  wire logic                    clock,
  input  wire logic [`PBF_B_WIDTH-1:0] b_out,
  input  wire logic [`PBF_B_WIDTH-1:0] b_oe,
  input  wire logic [`PBF_B_WIDTH-1:0] b_pull,
  input  wire logic [`PBF_F_WIDTH-1:0] f_out,
  input  wire logic [`PBF_F_WIDTH-1:0] f_oe,
  input  wire logic [`PBF_F_WIDTH-1:0] f_pull,
  input  wire logic                    brd_en,
  input  wire logic [`PBF_B_WIDTH-1:0] brd_b,
  input  wire logic [`PBF_F_WIDTH-1:0] brd_f,
  output logic      [`PBF_B_WIDTH-1:0] b_level,
  output logic      [`PBF_F_WIDTH-1:0] f_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;  // stands in for a floating line, never a steady value
  always @(posedge clock) flip <= ~flip;
  // chip drive wins, then board drive, then pullup, else floating
  always_comb begin
    for (int i = 0; i < `PBF_B_WIDTH; i++) begin
      b_level[i] = b_oe[i] ? b_out[i] : brd_en ? brd_b[i] : b_pull[i] ? 1'b1 : flip;
    end
    for (int i = 0; i < `PBF_F_WIDTH; i++) begin
      f_level[i] = f_oe[i] ? f_out[i] : brd_en ? brd_f[i] : f_pull[i] ? 1'b1 : flip;
    end
  end
endmodule  // pbf_board_model

/* sim/pbf_pin_mux_tb.sv */
// self-checking testbench for the port b / port f pin mux
module pbf_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clock = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  cfg_wr = 1'b0;
  pbf_pkg::pbf_cfg_sel_t cfg_sel = pbf_pkg::PBF_SEL_B_DATA;
  logic [4:0]            cfg_wdata = 5'h00;
  logic                  ext_bus_active = 1'b0;
  logic                  ext_data_write = 1'b0;
  logic [4:0]            ext_addr = 5'h00;
  logic [3:0]            ext_data_out = 4'h0;
  logic                  prescaler_clock = 1'b0;
  logic                  brd_en = 1'b0;
  logic [4:0]            brd_b = 5'h00;
  logic [3:0]            brd_f = 4'h0;
  logic [4:0]            b_lvl, b_out, b_oe, b_pull, b_in, b_per;
  logic [3:0]            f_lvl, f_out, f_oe, f_pull, f_in, f_per;
  logic                  ctrl_oe;
  int                    mismatches = 0;
  int                    total_checks = 0;

  always #2.5 clock = ~clock;

  pbf_pin_mux dut_u (.clock(clock), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_wdata(cfg_wdata), .ext_bus_active(ext_bus_active), .ext_data_write(ext_data_write),
    .ext_addr(ext_addr), .ext_data_out(ext_data_out), .prescaler_clock(prescaler_clock),
    .port_b_pin_in(b_lvl), .port_f_pin_in(f_lvl), .port_b_pin_out(b_out),
    .port_b_pin_oe(b_oe), .port_b_pullup(b_pull), .port_f_pin_out(f_out),
    .port_f_pin_oe(f_oe), .port_f_pullup(f_pull), .port_b_in(b_in), .port_f_in(f_in),
    .port_b_peripheral_enable(b_per), .port_f_peripheral_enable(f_per), .ext_ctrl_oe(ctrl_oe));

  pbf_board_model brd_u (.clock(clock), .b_out(b_out), .b_oe(b_oe), .b_pull(b_pull),
    .f_out(f_out), .f_oe(f_oe), .f_pull(f_pull), .brd_en(brd_en), .brd_b(brd_b),
    .brd_f(brd_f), .b_level(b_lvl), .f_level(f_lvl));

  // compare and count
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one config write, strobe held for one edge
  task automatic wr(input pbf_pkg::pbf_cfg_sel_t s, input logic [4:0] d);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_sel <= s;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask

  // set external bus state, then let the registered pins follow
  task automatic bus(input logic act, input logic wrt);
    @(posedge clock);
    ext_bus_active <= act;
    ext_data_write <= wrt;
    settle();
  endtask

  // pins answer two edges after a write; wait three and sample off the edge
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic t_reset();
    chk(b_oe, 5'h00);
    chk(b_per, 5'h00);
    chk({1'b0, f_per}, 5'h0f);
    chk(b_pull, 5'h1f);
    chk({1'b0, f_pull}, 5'h0f);
    chk({4'h0, ctrl_oe}, 5'h00);
    $display("test reset done");
  endtask

  task automatic t_gpio();
    wr(pbf_pkg::PBF_SEL_F_PER, 5'h00);
    wr(pbf_pkg::PBF_SEL_B_DATA, 5'h15);
    wr(pbf_pkg::PBF_SEL_B_DIR, 5'h0e);
    wr(pbf_pkg::PBF_SEL_F_DATA, 5'h0a);
    wr(pbf_pkg::PBF_SEL_F_DIR, 5'h06);
    settle();
    chk(b_oe, 5'h0e);
    chk(b_out & b_oe, 5'h04);
    chk({1'b0, f_oe}, 5'h06);
    chk({1'b0, f_out & f_oe}, 5'h02);
    $display("test gpio done");
  endtask

  task automatic t_pullup();
    wr(pbf_pkg::PBF_SEL_B_PUR, 5'h1d);
    wr(pbf_pkg::PBF_SEL_F_PUR, 5'h0e);
    settle();
    chk(b_pull, 5'h1d);
    chk({1'b0, f_pull}, 5'h0e);
    wr(pbf_pkg::PBF_SEL_B_PUR, 5'h0f);
    wr(pbf_pkg::PBF_SEL_F_PUR, 5'h0f);
    settle();
    chk(b_pull, 5'h0f);
    $display("test pullup done");
  endtask

  task automatic t_bus();
    @(posedge clock);
    ext_addr <= 5'h0a;
    ext_data_out <= 4'h6;
    wr(pbf_pkg::PBF_SEL_B_PER, 5'h0f);
    wr(pbf_pkg::PBF_SEL_F_PER, 5'h0f);
    bus(1'b0, 1'b0);
    chk({ctrl_oe, b_oe[3:0]}, 5'h00);
    chk({1'b0, f_oe}, 5'h00);
    bus(1'b1, 1'b1);
    chk({ctrl_oe, b_oe[3:0]}, 5'h1f);
    chk({1'b0, b_out[3:0]}, 5'h0a);
    chk({1'b0, f_oe}, 5'h0f);
    chk({1'b0, f_out}, 5'h06);
    bus(1'b1, 1'b0);
    chk({1'b0, f_oe}, 5'h00);
    wr(pbf_pkg::PBF_SEL_DRIVE, 5'h01);
    bus(1'b0, 1'b0);
    chk({ctrl_oe, b_oe[3:0]}, 5'h1f);
    chk({1'b0, f_oe}, 5'h0f);
    wr(pbf_pkg::PBF_SEL_DRIVE, 5'h00);
    $display("test bus done");
  endtask

  task automatic t_clock_out();
    ext_addr <= 5'h10;
    wr(pbf_pkg::PBF_SEL_B_PER, 5'h1f);
    bus(1'b1, 1'b0);
    chk({3'h0, b_oe[4], b_out[4]}, 5'h03);
    wr(pbf_pkg::PBF_SEL_CLKOUT, 5'h01);
    ext_addr <= 5'h00;
    prescaler_clock <= 1'b1;
    bus(1'b0, 1'b0);
    chk({3'h0, b_oe[4], b_out[4]}, 5'h03);
    @(posedge clock);
    prescaler_clock <= 1'b0;
    settle();
    chk({3'h0, b_oe[4], b_out[4]}, 5'h02);
    wr(pbf_pkg::PBF_SEL_CLKOUT, 5'h00);
    $display("test clock out done");
  endtask

  task automatic t_input();
    wr(pbf_pkg::PBF_SEL_B_PER, 5'h00);
    wr(pbf_pkg::PBF_SEL_F_PER, 5'h00);
    wr(pbf_pkg::PBF_SEL_B_DIR, 5'h00);
    wr(pbf_pkg::PBF_SEL_F_DIR, 5'h00);
    brd_b <= 5'h16;
    brd_f <= 4'h9;
    brd_en <= 1'b1;
    repeat (3) settle();
    chk(b_in, 5'h16);
    chk({1'b0, f_in}, 5'h09);
    $display("test input done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog: a hung run counts as a mismatch
  initial begin
    #100000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    t_reset();
    t_gpio();
    t_pullup();
    t_bus();
    t_clock_out();
    t_input();
    close_out();
  end
endmodule  // pbf_pin_mux_tb
